/* logic/hbs_regs.sv */
// Purpose: Receive code status, receive FIFO read port, transmit FIFO status
// Assumes: Host read/write strobes are one-cycle pulses synchronous to i_core_clk
// Notes:   Read data is registered one cycle after the read strobe
//          Unassigned and unmapped bits read as zero
//
// Functional notes
// - Latched detect bit 7, cleared on read
// - Live detect bit 6 follows detector
// - Code bits 5..0, bit 0 first received
// - Code holds last verified value; reset all ones
// - Receive FIFO byte at offset 0x05
// - Offset 0x06 shows empty, full, underrun
// - Bits 7..3 of 0x06 unassigned, ignore
// - Underrun sets on early empty; read clears
// - Code change interrupt gated by mask bit
`timescale 1ns/1ps
module hbs_regs (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Host control port
  input  wire logic        i_host_rd,
  input  wire logic        i_host_wr,
  input  wire logic [7:0]  i_host_addr,
  input  wire logic [7:0]  i_host_wdata,
  output logic      [7:0]  o_host_rdata,
  // Code detector
  input  wire logic        i_code_live,
  input  wire logic        i_code_valid,
  input  wire logic [5:0]  i_code_word,
  output logic             o_code_change_irq,
  // Receive HDLC byte stream
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_ready,
  // Transmit HDLC FIFO and serializer
  input  wire logic        i_tx_fifo_empty,
  input  wire logic        i_tx_fifo_full,
  input  wire logic        i_tx_byte_req,
  input  wire logic        i_tx_msg_active,
  input  wire logic        i_tx_end_marked,
  output logic             o_tx_abort
);
  typedef struct packed {
    logic [7:0] rdata;
    logic       latched;
    logic       live_prev;
    logic [5:0] code;
    logic       mask;
    logic       irq;
    logic       underrun;
    logic       abort;
  } hbs_state_t;

  hbs_state_t st_q;
  hbs_state_t st_d;

  // Whole-state image loaded by reset
  localparam hbs_state_t ST_RST = '{
    rdata:     hbs_pkg::RST_RDATA,
    latched:   1'b0,
    live_prev: 1'b0,
    code:      hbs_pkg::RST_CODE,
    mask:      1'b0,
    irq:       1'b0,
    underrun:  1'b0,
    abort:     1'b0
  };

  // Receive buffer handshake
  logic       buf_valid;
  logic [7:0] buf_data;
  logic       buf_pop;

  // Strobes decoded per register
  logic       rd_code;
  logic       rd_fifo;
  logic       rd_txst;
  logic       rd_other;
  logic       wr_mask;

  // Register images and the selected one
  logic [7:0] code_view;
  logic [7:0] fifo_view;
  logic [7:0] txst_view;
  logic [7:0] rdata_sel;

  // Events of this cycle
  logic       live_change;
  logic       tx_starved;
  logic       msg_open;
  logic       underrun_evt;

  // Two-entry buffer between receive stream and host
  hbs_rx_buf u_rx_buf (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_rx_valid),
    .i_in_data   (i_rx_data),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (buf_valid),
    .o_out_data  (buf_data),
    .i_out_ready (buf_pop)
  );

  // Address decode of the host strobes
  always_comb begin
    rd_code  = 1'b0;
    rd_fifo  = 1'b0;
    rd_txst  = 1'b0;
    rd_other = 1'b0;
    wr_mask  = 1'b0;
    if (i_host_rd && (i_host_addr == hbs_pkg::OFF_RX_BIT_CODE)) begin
      rd_code = 1'b1;
    end else if (i_host_rd && (i_host_addr == hbs_pkg::OFF_RX_HDLC_FIFO)) begin
      rd_fifo = 1'b1;
    end else if (i_host_rd && (i_host_addr == hbs_pkg::OFF_TX_HDLC_STATUS)) begin
      rd_txst = 1'b1;
    end else if (i_host_rd) begin
      rd_other = 1'b1;
    end
    if (i_host_wr && (i_host_addr == hbs_pkg::OFF_IRQ_MASK)) begin
      wr_mask = 1'b1;
    end
  end

  // Register images as the host sees them
  always_comb begin
    // Bit 0 holds the first code bit received
    code_view                            = 8'h00;
    code_view[hbs_pkg::POS_CODE_LATCHED] = st_q.latched;
    code_view[hbs_pkg::POS_CODE_LIVE]    = i_code_live;
    code_view[hbs_pkg::CODE_W-1:0]       = st_q.code;

    // Empty buffer reads as zero and pops nothing
    fifo_view = hbs_pkg::EMPTY_RDATA;
    if (buf_valid) begin
      fifo_view = buf_data;
    end

    // Unassigned status bits read as zero
    txst_view                           = 8'h00;
    txst_view[hbs_pkg::POS_TX_EMPTY]    = i_tx_fifo_empty;
    txst_view[hbs_pkg::POS_TX_FULL]     = i_tx_fifo_full;
    txst_view[hbs_pkg::POS_TX_UNDERRUN] = st_q.underrun;
  end

  // Read data source; unmapped addresses read zero
  always_comb begin
    rdata_sel = 8'h00;
    if (rd_code) begin
      rdata_sel = code_view;
    end else if (rd_fifo) begin
      rdata_sel = fifo_view;
    end else if (rd_txst) begin
      rdata_sel = txst_view;
    end
  end

  // Events of this cycle
  always_comb begin
    live_change  = (i_code_live != st_q.live_prev);
    // Starved byte request inside an open message
    tx_starved   = i_tx_byte_req && i_tx_fifo_empty;
    msg_open     = i_tx_msg_active && !i_tx_end_marked;
    underrun_evt = tx_starved && msg_open;
    buf_pop      = rd_fifo && buf_valid;
  end

  // Next state of every register
  always_comb begin
    st_d = st_q;

    // Read data loads on any read, then stands
    if (rd_code || rd_fifo || rd_txst || rd_other) begin
      st_d.rdata = rdata_sel;
    end

    if (wr_mask) begin
      st_d.mask = i_host_wdata[hbs_pkg::POS_MASK_CODE];
    end

    // Set wins over the clear on read
    if (rd_code) begin
      st_d.latched = 1'b0;
    end
    if (i_code_live) begin
      st_d.latched = 1'b1;
    end

    // Only a verified code replaces the stored one
    if (i_code_valid) begin
      st_d.code = i_code_word;
    end

    // One-cycle pulse on either edge of live detect
    st_d.live_prev = i_code_live;
    st_d.irq       = st_q.mask && live_change;

    // Set wins over the clear on read
    if (rd_txst) begin
      st_d.underrun = 1'b0;
    end
    if (underrun_evt) begin
      st_d.underrun = 1'b1;
    end
    st_d.abort = underrun_evt;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_host_rdata      = st_q.rdata;
  assign o_code_change_irq = st_q.irq;
  assign o_tx_abort        = st_q.abort;
endmodule

/* logic/hbs_pkg.sv */
// Purpose: Shared constants for the code status and HDLC FIFO register slice
// Assumes: Byte-wide host control port, 8-bit registers
// Notes:   Offsets are byte addresses on the control port
package hbs_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 6;

  localparam logic [7:0] OFF_IRQ_MASK       = 8'h02;
  localparam logic [7:0] OFF_RX_BIT_CODE    = 8'h04;
  localparam logic [7:0] OFF_RX_HDLC_FIFO   = 8'h05;
  localparam logic [7:0] OFF_TX_HDLC_STATUS = 8'h06;

  localparam int unsigned POS_CODE_LATCHED = 7;
  localparam int unsigned POS_CODE_LIVE    = 6;
  localparam int unsigned POS_MASK_CODE    = 7;
  localparam int unsigned POS_TX_EMPTY     = 2;
  localparam int unsigned POS_TX_FULL      = 1;
  localparam int unsigned POS_TX_UNDERRUN  = 0;

  localparam logic [5:0] RST_CODE     = 6'h3f;
  localparam logic [7:0] RST_RDATA    = 8'h00;
  localparam logic [7:0] EMPTY_RDATA  = 8'h00;
  localparam logic [1:0] BUF_DEPTH    = 2'h2;
endpackage

/* logic/hbs_rx_buf.sv */
// Purpose: Two-entry receive byte buffer with valid/ready on both sides
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Ready and valid outputs are registered
`timescale 1ns/1ps
module hbs_rx_buf (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_in_valid,
  input  wire logic [hbs_pkg::DATA_W-1:0]   i_in_data,
  output logic                              o_in_ready,
  output logic                              o_out_valid,
  output logic [hbs_pkg::DATA_W-1:0]        o_out_data,
  input  wire logic                         i_out_ready
);
  typedef struct packed {
    logic [1:0]                  count;
    logic [hbs_pkg::DATA_W-1:0]  head;
    logic [hbs_pkg::DATA_W-1:0]  tail;
    logic                        ready;
    logic                        valid;
  } hbs_buf_t;

  hbs_buf_t st_q;
  hbs_buf_t st_d;
  logic     push;
  logic     pop;

  always_comb begin
    st_d = st_q;
    pop  = i_out_ready && st_q.valid;
    push = i_in_valid && st_q.ready;
    if (push && pop) begin
      if (st_q.count == 2'h1) begin
        st_d.head = i_in_data;
      end else begin
        st_d.head = st_q.tail;
        st_d.tail = i_in_data;
      end
    end else if (push) begin
      if (st_q.count == 2'h0) begin
        st_d.head = i_in_data;
      end else begin
        st_d.tail = i_in_data;
      end
      st_d.count = st_q.count + 2'h1;
    end else if (pop) begin
      st_d.head  = st_q.tail;
      st_d.count = st_q.count - 2'h1;
    end
    st_d.ready = (st_d.count != hbs_pkg::BUF_DEPTH);
    st_d.valid = (st_d.count != 2'h0);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '{count: 2'h0, head: 8'h00, tail: 8'h00, ready: 1'b1, valid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_in_ready  = st_q.ready;
  assign o_out_valid = st_q.valid;
  assign o_out_data  = st_q.head;
endmodule

/* test/hbs_regs_props.sv */
// Purpose: Port checker for the code status and HDLC FIFO register slice
// Assumes: Read data is valid one cycle after the read edge
// Notes:   Bound to hbs_regs by port name
`timescale 1ns/1ps
module hbs_regs_props (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_host_rd,
  input  wire logic [7:0] i_host_addr,
  input  wire logic [7:0] o_host_rdata,
  input  wire logic       i_code_live,
  input  wire logic       i_code_valid,
  input  wire logic [5:0] i_code_word,
  input  wire logic       i_tx_fifo_empty,
  input  wire logic       i_tx_fifo_full,
  input  wire logic       i_tx_byte_req,
  input  wire logic       i_tx_msg_active,
  input  wire logic       i_tx_end_marked,
  input  wire logic       o_tx_abort
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire rd_code = i_host_rd && (i_host_addr == 8'h04);
  wire rd_tx   = i_host_rd && (i_host_addr == 8'h06);
  wire udr     = i_tx_byte_req && i_tx_fifo_empty && i_tx_msg_active && !i_tx_end_marked;
  sequence s_code_read; i_code_valid ##1 !i_code_valid ##1 (rd_code && !i_code_valid); endsequence
  sequence s_udr_read; udr ##1 !rd_tx ##1 rd_tx; endsequence
  a_live_bit: assert property (rd_code |=> o_host_rdata[6] == $past(i_code_live))
    else $error("live bit wrong");
  a_latch_set: assert property (rd_code && $past(i_code_live) |=> o_host_rdata[7])
    else $error("latched bit lost");
  a_code_word: assert property (
    s_code_read |=> o_host_rdata[5:0] == $past(i_code_word, 3))
    else $error("code word wrong");
  a_tx_levels: assert property (rd_tx |=> o_host_rdata[2:1] ==
    {$past(i_tx_fifo_empty), $past(i_tx_fifo_full)})
    else $error("fifo levels wrong");
  a_udr_flag: assert property (s_udr_read |=> o_host_rdata[0])
    else $error("underrun flag lost");
  a_abort_set: assert property (udr |=> o_tx_abort)
    else $error("abort missing");
  a_abort_only: assert property (!udr |=> !o_tx_abort)
    else $error("abort without cause");
  a_rdata_hold: assert property (!i_host_rd |=> $stable(o_host_rdata))
    else $error("read data moved");
endmodule
bind hbs_regs hbs_regs_props i_hbs_regs_props (.*);

/* test/hbs_far_end.sv */
// Purpose: Far-end model: code detector and receive byte source
// Assumes: A byte offer is held until the block takes it or 50 cycles pass
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
module hbs_far_end (
  input  wire logic       i_core_clk,
  input  wire logic       i_rx_ready,
  output logic            o_rx_valid = 1'b0,
  output logic      [7:0] o_rx_data = 8'h00,
  output logic            o_code_live = 1'b0,
  output logic            o_code_valid = 1'b0,
  output logic      [5:0] o_code_word = 6'h00
);
  task automatic send_byte(input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    @(posedge i_core_clk) o_rx_valid <= 1'b1;
    o_rx_data <= b;
    do @(posedge i_core_clk); while (!i_rx_ready && ++n < 50);
    ok = (n < 50);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~b;
  endtask
  task automatic code(input logic live, input logic vld, input logic [5:0] w);
    @(posedge i_core_clk) o_code_live <= live;
    o_code_valid <= vld;
    o_code_word <= w;
    @(posedge i_core_clk) o_code_valid <= 1'b0;
    o_code_word <= ~w;
  endtask
endmodule

/* test/hbs_regs_tb.sv */
// Purpose: Register level test of the code status and HDLC FIFO slice
// Assumes: Host strobes are one-cycle pulses
// Notes:   Far end supplies code and receive bytes
`timescale 1ns/1ps
module hbs_regs_tb;
  logic       i_core_clk, i_rst, i_host_rd, i_host_wr, i_code_live, i_code_valid, i_rx_valid;
  logic       o_code_change_irq, o_rx_ready, o_tx_abort, i_tx_fifo_empty, i_tx_fifo_full;
  logic       i_tx_byte_req, i_tx_msg_active, i_tx_end_marked;
  logic [7:0] i_host_addr, i_host_wdata, o_host_rdata, i_rx_data;
  logic [5:0] i_code_word;
  logic       sent_ok;
  int         mismatches = 0;
  int         n_compared = 0;
  hbs_far_end i_hbs_far_end (.i_core_clk(i_core_clk), .i_rx_ready(o_rx_ready),
    .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_code_live(i_code_live),
    .o_code_valid(i_code_valid), .o_code_word(i_code_word));
  hbs_regs i_hbs_regs (.*);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d, m, e);
    @(posedge i_core_clk) {i_host_wr, i_host_rd} <= {w, !w};
    {i_host_addr, i_host_wdata} <= {a, d};
    @(posedge i_core_clk) {i_host_wr, i_host_rd} <= 2'h0;
    #1 if (!w) chk($sformatf("reg %h", a), e, o_host_rdata & m);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (3000) @(posedge i_core_clk);
    mismatches++;
    results;
  end
  initial begin
    {i_rst, i_host_rd, i_host_wr, i_tx_byte_req, i_tx_msg_active, i_tx_end_marked} = 6'h20;
    {i_host_addr, i_host_wdata, i_tx_fifo_empty, i_tx_fifo_full} = 18'h00002;
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    acc(0, 8'h04, 0, 8'hff, 8'h3f);
    acc(0, 8'h06, 0, 8'h07, 8'h04);
    acc(0, 8'h01, 0, 8'hff, 8'h00);
    acc(1, 8'h02, 8'h80, 0, 0);
    i_hbs_far_end.code(1'b1, 1'b1, 6'h2a);
    #1 chk("irq rise", 8'h01, {7'h00, o_code_change_irq});
    i_hbs_far_end.code(1'b0, 1'b0, 6'h15);
    #1 chk("irq fall", 8'h01, {7'h00, o_code_change_irq});
    acc(0, 8'h04, 0, 8'hff, 8'haa);
    chk("irq idle", 8'h00, {7'h00, o_code_change_irq});
    acc(0, 8'h04, 0, 8'hff, 8'h2a);
    i_hbs_far_end.code(1'b1, 1'b1, 6'h07);
    acc(0, 8'h04, 0, 8'hff, 8'hc7);
    fork
      for (int k = 1; k < 4; k++) begin
        i_hbs_far_end.send_byte(8'(k * 17), sent_ok);
        if (!sent_ok) mismatches++;
      end
    join_none
    repeat (12) @(posedge i_core_clk);
    #1 chk("rx ready", 8'h00, {7'h00, o_rx_ready});
    for (int k = 1; k < 5; k++) acc(0, 8'h05, 0, 8'hff, k < 4 ? 8'(k * 17) : 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_core_clk) {i_tx_byte_req, i_tx_msg_active, i_tx_end_marked} <= {2'h3, k[0]};
      @(posedge i_core_clk) i_tx_byte_req <= 1'b0;
      #1 chk("abort", {7'h00, k == 0}, {7'h00, o_tx_abort});
      acc(0, 8'h06, 0, 8'h07, k ? 8'h04 : 8'h05);
    end
    @(posedge i_core_clk) {i_tx_fifo_empty, i_tx_fifo_full} <= 2'h1;
    acc(0, 8'h06, 0, 8'h07, 8'h02);
    results;
  end
endmodule
